// File: calendar_alarm_pkg.sv
// Constants, register map and field layout of the calendar and alarm bank
// ----------------------------------------------------------------------
// Operation
// - Day of month: tens 15:12, units 11:8
// - Day tens upper two bits read zero
// - Weekday digit in bits 3:0, 0 to 6
// - Weekday digit top bit reads zero
// - Alarm seconds: tens 15:12, units 11:8
// - Alarm seconds tens top bit reads zero
// - Clear alias zeroes bits written one
// - Set alias forces bits written one
// - Invert alias toggles bits written one
// - Zero bits in alias writes change nothing
// - Aliases are write-only, reads undefined
// - Aliases never touch unimplemented bits
// - Flag bit 15 set by clock event
// - Enable bit 15 gates clock interrupt
// - Calendar date writes need write-enable control bit
// ----------------------------------------------------------------------
package calendar_alarm_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] CALENDAR_DATE_OFFSET  = 8'h00;
	localparam logic [7:0] ALARM_TIME_OFFSET     = 8'h10;
	localparam logic [7:0] ALARM_DATE_OFFSET     = 8'h20;
	localparam logic [7:0] IRQ_FLAGS_OFFSET      = 8'h30;
	localparam logic [7:0] IRQ_ENABLES_OFFSET    = 8'h34;
	localparam logic [7:0] CLOCK_CONTROL_OFFSET  = 8'h38;

	// Within a value group, address bits 3:2 pick the access kind
	typedef enum logic [1:0]
	{
		OP_WRITE  = 2'b00,
		OP_CLEAR  = 2'b01,
		OP_SET    = 2'b10,
		OP_INVERT = 2'b11
	} alias_op_t;

	// Implemented storage bits of each value register
	localparam logic [31:0] CALENDAR_DATE_MASK = 32'hff1f3f07;
	localparam logic [31:0] ALARM_TIME_MASK    = 32'h3f7f7f00;
	localparam logic [31:0] ALARM_DATE_MASK    = 32'h001f3f07;

	// Reset values
	localparam logic [31:0] VALUE_RESET        = 32'h00000000;
	localparam logic        FLAG_RESET         = 1'b0;

	// Field positions
	localparam int          CLOCK_IRQ_BIT      = 15;
	localparam int          WRITE_ENABLE_BIT   = 3;

endpackage

// File: alias_value_reg.sv
// Value register with plain, clear, set and invert write aliases
module alias_value_reg
	import calendar_alarm_pkg::*;
#(
	parameter logic [31:0] MASK  = 32'hffffffff,
	parameter logic [31:0] RESET = 32'h00000000
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_en,
	input  wire alias_op_t   op,
	input  wire logic [31:0] wdata,
	output logic [31:0]      value_q
);

	// Next value for each access kind, limited to implemented bits
	function automatic logic [31:0] alias_next(input logic [31:0] cur,
		input logic [31:0] wd, input alias_op_t kind);
		logic [31:0] res;
		res = cur;
		unique case (kind)
			OP_WRITE:  res = wd;
			OP_CLEAR:  res = cur & ~wd;
			OP_SET:    res = cur | wd;
			OP_INVERT: res = cur ^ wd;
		endcase
		return res & MASK;
	endfunction

	// Storage; unimplemented bits stay zero and read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			value_q <= RESET & MASK;
		else if (wr_en)
			value_q <= alias_next(value_q, wdata, op);
	end

endmodule

// File: clock_irq_unit.sv
// Pending flag, enable bit and level interrupt of the clock module
module clock_irq_unit
	import calendar_alarm_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clock_event,
	input  wire logic flag_clear,
	input  wire logic enable_wr,
	input  wire logic enable_data,
	output logic      clock_irq_flag_q,
	output logic      clock_irq_enable_q,
	output logic      clock_irq_q
);

	// Sticky flag; an event in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clock_irq_flag_q <= FLAG_RESET;
		else if (clock_event)
			clock_irq_flag_q <= 1'b1;
		else if (flag_clear)
			clock_irq_flag_q <= 1'b0;
	end

	// Software-owned enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clock_irq_enable_q <= FLAG_RESET;
		else if (enable_wr)
			clock_irq_enable_q <= enable_data;
	end

	// Level interrupt while the flag is pending and enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clock_irq_q <= 1'b0;
		else
			clock_irq_q <= clock_irq_flag_q & clock_irq_enable_q;
	end

endmodule

// File: calendar_alarm_register_bank.sv
// APB register bank for calendar date, alarm values and clock interrupt
//
// Register access over APB and the register addresses were chosen for this implementation.
module calendar_alarm_register_bank
	import calendar_alarm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic        clock_event,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      calendar_date,
	output logic [31:0]      alarm_time_value,
	output logic [31:0]      alarm_date_value,
	output logic             value_write_enable,
	output logic             clock_irq
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------

	// Value group base of an address, alias bits dropped
	function automatic logic [7:0] group_base(input logic [7:0] addr);
		return {addr[7:4], 4'h0};
	endfunction

	// True when the address hits a value group
	function automatic logic is_value_group(input logic [7:0] addr);
		logic [7:0] base;
		base = group_base(addr);
		return (base == CALENDAR_DATE_OFFSET) ||
			(base == ALARM_TIME_OFFSET) ||
			(base == ALARM_DATE_OFFSET);
	endfunction

	// True when the address hits any mapped word
	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr[1:0] == 2'b00) && (is_value_group(addr) ||
			(addr == IRQ_FLAGS_OFFSET) ||
			(addr == IRQ_ENABLES_OFFSET) ||
			(addr == CLOCK_CONTROL_OFFSET));
	endfunction

	logic        access_phase;
	logic        commit;
	logic        do_write;
	alias_op_t   op;
	logic [31:0] wdata_eff;
	logic        wr_date;
	logic        wr_alarm_time;
	logic        wr_alarm_date;
	logic        wr_flags;
	logic        wr_enables;
	logic        wr_control;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        write_enable_q;
	logic        clock_irq_flag;
	logic        clock_irq_enable;
	logic        clock_irq_q;
	logic [31:0] date_q;
	logic [31:0] alarm_time_q;
	logic [31:0] alarm_date_q;

	// Access phase and the edge at which the transfer completes
	assign access_phase = psel & penable;
	assign commit       = access_phase & pready_q;
	assign do_write     = commit & pwrite & ~pslverr_q;
	assign op           = alias_op_t'(paddr[3:2]);

	// Byte strobes qualify write data; a dropped lane writes zeros,
	// which under the aliases leaves those bits alone
	always_comb
	begin
		wdata_eff = 32'h00000000;
		for (int i = 0; i < 4; i++)
		begin
			if (pstrb[i])
				wdata_eff[i*8 +: 8] = pwdata[i*8 +: 8];
		end
	end

	// Per-register write strobes
	assign wr_date       = do_write & write_enable_q &
		(group_base(paddr) == CALENDAR_DATE_OFFSET);
	assign wr_alarm_time = do_write &
		(group_base(paddr) == ALARM_TIME_OFFSET);
	assign wr_alarm_date = do_write &
		(group_base(paddr) == ALARM_DATE_OFFSET);
	assign wr_flags      = do_write & (paddr == IRQ_FLAGS_OFFSET);
	assign wr_enables    = do_write & (paddr == IRQ_ENABLES_OFFSET);
	assign wr_control    = do_write & (paddr == CLOCK_CONTROL_OFFSET);

	// ------------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------------

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_q <= 1'b0;
		else if (commit)
			pready_q <= 1'b0;
		else if (access_phase)
			pready_q <= 1'b1;
	end

	// Error answer for unmapped or misaligned words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_q <= 1'b0;
		else if (commit)
			pslverr_q <= 1'b0;
		else if (access_phase)
			pslverr_q <= ~is_mapped(paddr);
	end

	// Read data, captured in the wait cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (commit)
			prdata_q <= 32'h00000000;
		else if (access_phase && !pwrite)
		begin
			prdata_q <= 32'h00000000;
			if (is_value_group(paddr) && paddr[3:2] == 2'b00)
			begin
				// Stored masks keep fixed-zero digit bits at zero
				unique case (group_base(paddr))
					CALENDAR_DATE_OFFSET:
						prdata_q <= date_q;
					ALARM_TIME_OFFSET:
						prdata_q <= alarm_time_q;
					ALARM_DATE_OFFSET:
						prdata_q <= alarm_date_q;
					default:
						prdata_q <= 32'h00000000;
				endcase
			end
			else if (paddr == IRQ_FLAGS_OFFSET)
				prdata_q[CLOCK_IRQ_BIT] <= clock_irq_flag;
			else if (paddr == IRQ_ENABLES_OFFSET)
				prdata_q[CLOCK_IRQ_BIT] <= clock_irq_enable;
			else if (paddr == CLOCK_CONTROL_OFFSET)
				prdata_q[WRITE_ENABLE_BIT] <= write_enable_q;
			// Alias words read zero; software must not rely on it
		end
	end

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------

	// Write-enable for the calendar date value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			write_enable_q <= 1'b0;
		else if (wr_control)
			write_enable_q <= wdata_eff[WRITE_ENABLE_BIT];
	end

	// ------------------------------------------------------------------
	// Value registers
	// ------------------------------------------------------------------

	// Calendar date: year, month, day and weekday digits
	alias_value_reg #(
		.MASK  (CALENDAR_DATE_MASK),
		.RESET (VALUE_RESET)
	) u_date (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_date),
		.op      (op),
		.wdata   (wdata_eff),
		.value_q (date_q)
	);

	// Alarm time: hours, minutes and seconds digits
	alias_value_reg #(
		.MASK  (ALARM_TIME_MASK),
		.RESET (VALUE_RESET)
	) u_alarm_time (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_alarm_time),
		.op      (op),
		.wdata   (wdata_eff),
		.value_q (alarm_time_q)
	);

	// Alarm date: month, day and weekday digits
	alias_value_reg #(
		.MASK  (ALARM_DATE_MASK),
		.RESET (VALUE_RESET)
	) u_alarm_date (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_alarm_date),
		.op      (op),
		.wdata   (wdata_eff),
		.value_q (alarm_date_q)
	);

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------

	// Flag cleared by writing one to bit 15; hardware never clears it
	clock_irq_unit u_irq (
		.pclk               (pclk),
		.presetn            (presetn),
		.clock_event        (clock_event),
		.flag_clear         (wr_flags & wdata_eff[CLOCK_IRQ_BIT]),
		.enable_wr          (wr_enables),
		.enable_data        (wdata_eff[CLOCK_IRQ_BIT]),
		.clock_irq_flag_q   (clock_irq_flag),
		.clock_irq_enable_q (clock_irq_enable),
		.clock_irq_q        (clock_irq_q)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// All outputs come straight from flip-flops
	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign calendar_date      = date_q;
	assign alarm_time_value   = alarm_time_q;
	assign alarm_date_value   = alarm_date_q;
	assign value_write_enable = write_enable_q;
	assign clock_irq          = clock_irq_q;

endmodule

// File: calendar_alarm_properties.sv
// Port checker for the calendar and alarm register bank
module calendar_alarm_properties
	import calendar_alarm_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        clock_event,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] calendar_date,
	input wire logic [31:0] alarm_time_value,
	input wire logic [31:0] alarm_date_value,
	input wire logic        value_write_enable,
	input wire logic        clock_irq
);
	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Completed write and the fixed one wait state answer
	sequence wr_done;
		psel && penable && pready && pwrite;
	endsequence
	sequence wait_then_ready;
		!pready ##1 pready;
	endsequence

	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held for more than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_ready_wait: assert property (psel && !penable |=> wait_then_ready)
		else $error("answer not in second access cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property (pready && paddr > 8'h38 |-> pslverr)
		else $error("unmapped address not refused");
	a_date_locked: assert property (wr_done ##0
		(paddr[7:4] == 4'h0 && !value_write_enable)
		|=> $stable(calendar_date))
		else $error("date changed while writes locked");
	a_alias_reads: assert property (pready && !pwrite && paddr < 8'h30
		&& paddr[1:0] == 2'b00 && paddr[3:2] != 2'b00 |-> prdata == 32'h0)
		else $error("alias read not zero");
	a_date_fields: assert property (
		(calendar_date & ~CALENDAR_DATE_MASK) == 0)
		else $error("date holds unimplemented bits");
	a_time_fields: assert property (
		(alarm_time_value & ~ALARM_TIME_MASK) == 0)
		else $error("alarm time holds unimplemented bits");
	a_adate_fields: assert property (
		(alarm_date_value & ~ALARM_DATE_MASK) == 0)
		else $error("alarm date holds unimplemented bits");
endmodule

bind calendar_alarm_register_bank calendar_alarm_properties
	calendar_alarm_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .clock_event(clock_event), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .calendar_date(calendar_date),
	.alarm_time_value(alarm_time_value), .alarm_date_value(alarm_date_value),
	.value_write_enable(value_write_enable), .clock_irq(clock_irq));

// File: calendar_alarm_register_bank_tb_top.sv
// Self-checking bench for the calendar and alarm register bank
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	mismatches++; $display("BAD %s expected %h seen %h", n, e, g); end end
module calendar_alarm_register_bank_tb_top
	import calendar_alarm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        clock_event = 0, pready, pslverr, value_write_enable;
	logic        clock_irq, er;
	logic [7:0]  paddr = 8'h00;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] pwdata = 32'h0, prdata, rd, e, wv, cal, atv, adv;
	logic [31:0] fin [3];
	int          mismatches = 0, checks_done = 0;
	logic [7:0]  regs [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h34, 8'h38};
	logic [7:0]  base [3] = '{8'h00, 8'h10, 8'h20};
	logic [31:0] msk [3] = '{CALENDAR_DATE_MASK, ALARM_TIME_MASK,
		ALARM_DATE_MASK};
	// Reserved ranges that software always writes as zero
	logic [31:0] rsv [3] = '{32'h000000f0, 32'h000000ff, 32'hff0000f0};
	logic [31:0] pat [4] = '{32'h5a5a5a5a, 32'h0f0f0f0f, 32'hf0f00f0f,
		32'hffff00ff};

	calendar_alarm_register_bank calendar_alarm_register_bank_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.clock_event(clock_event), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .calendar_date(cal), .alarm_time_value(atv),
		.alarm_date_value(adv), .value_write_enable(value_write_enable),
		.clock_irq(clock_irq));

	// ----------------------------------------------------------------
	// Clock, bus tasks and verdict
	// ----------------------------------------------------------------
	always #20 pclk = ~pclk;

	// One APB transfer; answer taken at the edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK("read data", x, rd)
		`CHK("read error", 1'b0, er)
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		#200000;
		mismatches++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) rdc(regs[i], 32'h0);
		$display("reset values done");
		wr(8'h00, 32'hffffff0f);
		rdc(8'h00, 32'h0);
		wr(8'h38, 32'h8);
		rdc(8'h38, 32'h8);
		`CHK("write enable port", 1'b1, value_write_enable)
		wr(8'h00, 32'hffffff0f);
		rdc(8'h00, CALENDAR_DATE_MASK);
		wr(8'h10, 32'hffffff00);
		rdc(8'h10, ALARM_TIME_MASK);
		wr(8'h20, 32'h00ffff0f);
		rdc(8'h20, ALARM_DATE_MASK);
		$display("field layout done");
		foreach (base[g])
		begin
			e = pat[0] & msk[g];
			wr(base[g], pat[0] & ~rsv[g]);
			rdc(base[g], e);
			for (int op = 1; op < 4; op++)
			begin
				wv = pat[op] & ~rsv[g];
				wr(base[g] + 8'(4 * op), wv);
				if (op == 1) e = e & ~wv;
				if (op == 2) e = (e | wv) & msk[g];
				if (op == 3) e = (e ^ wv) & msk[g];
				rdc(base[g], e);
				rdc(base[g] + 8'(4 * op), 32'h0);
			end
			fin[g] = e;
		end
		`CHK("date port", fin[0], cal)
		`CHK("alarm time port", fin[1], atv)
		`CHK("alarm date port", fin[2], adv)
		wr(8'h38, 32'h0);
		wr(8'h0c, 32'hffffff0f);
		wr(8'h08, 32'hffffff0f);
		rdc(8'h00, fin[0]);
		`CHK("write disable port", 1'b0, value_write_enable)
		$display("alias writes done");
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped error", 1'b1, er)
		apb(1'b1, 8'h11, 32'hffffffff);
		`CHK("misaligned error", 1'b1, er)
		rdc(8'h10, fin[1]);
		$display("refusals done");
		@(posedge pclk);
		clock_event <= 1'b1;
		@(posedge pclk);
		clock_event <= 1'b0;
		rdc(8'h30, 32'h8000);
		`CHK("irq while disabled", 1'b0, clock_irq)
		wr(8'h34, 32'h8000);
		rdc(8'h34, 32'h8000);
		`CHK("irq enabled", 1'b1, clock_irq)
		wr(8'h30, 32'h0);
		rdc(8'h30, 32'h8000);
		wr(8'h34, 32'h0);
		repeat (2) @(negedge pclk);
		`CHK("irq masked", 1'b0, clock_irq)
		wr(8'h34, 32'h8000);
		repeat (2) @(negedge pclk);
		`CHK("irq unmasked", 1'b1, clock_irq)
		wr(8'h30, 32'h8000);
		rdc(8'h30, 32'h0);
		`CHK("irq cleared", 1'b0, clock_irq)
		$display("interrupt done");
		give_verdict();
	end
endmodule
